// ==== hdl/cosp_pkg.sv ====
// Shared constants and types for the clock output stop and power-down control
package cosp_pkg;

    // System clock
    localparam real CLK_PERIOD_NS = 8.0;

    // Longest power-up latency, in milliseconds, and its cycle count (rounded down)
    localparam real PWRUP_MAX_MS = 1.8;
    localparam int PWRUP_MAX_CYC = $rtoi(PWRUP_MAX_MS * 1000000.0 / CLK_PERIOD_NS);

    // Rising edges of a complement clock on which a stop request must be seen
    localparam logic [1:0] SAMPLE_EDGES = 2'h2;

    // Default output counts
    localparam int N_CPU_DEF = 2;
    localparam int N_SRC_DEF = 3;
    localparam int N_PCI_DEF = 1;
    localparam int N_FREE_RUNNING_PCI_CLOCK_DEF = 1;

    // Control sequence
    typedef enum logic [2:0] {
        ST_WAIT_PG,
        ST_WAKE,
        ST_RUN,
        ST_PD_STOP,
        ST_PD_OFF
    } cosp_state_t;

endpackage : cosp_pkg

// ==== hdl/cosp_ctrl.sv ====
// Clock output stop, park, restart and power-down sequencing
`timescale 1ns/10ps
`default_nettype none

module cosp_ctrl #(
    parameter int N_CPU = cosp_pkg::N_CPU_DEF,
    parameter int N_SRC = cosp_pkg::N_SRC_DEF,
    parameter int N_PCI = cosp_pkg::N_PCI_DEF,
    parameter int N_FREE_RUNNING_PCI_CLOCK = cosp_pkg::N_FREE_RUNNING_PCI_CLOCK_DEF,
    parameter int PWRUP_CYC = cosp_pkg::PWRUP_MAX_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_power_good_strobe,
    input wire logic i_cpu_clock_stop_n,
    input wire logic i_pci_refclk_stop_n,
    input wire logic i_cpu_clk,
    input wire logic i_src_clk,
    input wire logic i_pci_clk,
    input wire logic i_pll_locked,
    input wire logic [N_CPU-1:0] i_cpu_stoppable,
    input wire logic [N_SRC-1:0] i_src_stoppable,
    input wire logic [N_FREE_RUNNING_PCI_CLOCK-1:0] i_free_running_pci_clock_stoppable,
    output logic [N_CPU-1:0] o_cpu_clock_true,
    output logic [N_CPU-1:0] o_cpu_clock_complement,
    output logic [N_SRC-1:0] o_pcie_reference_clock_true,
    output logic [N_SRC-1:0] o_pcie_reference_clock_complement,
    output logic [N_PCI-1:0] o_pci_clock,
    output logic [N_FREE_RUNNING_PCI_CLOCK-1:0] o_free_running_pci_clock,
    output logic o_diff_oe,
    output logic o_synth_enable,
    output logic o_inputs_valid,
    output logic o_powerup_late,
    output logic o_clocks_running
);

    localparam int TW = $clog2(PWRUP_CYC + 1);

    generate
        if (N_CPU < 1) begin : g_chk_cpu
            $error("cosp_ctrl: N_CPU must be at least 1");
        end
        if (N_SRC < 1) begin : g_chk_src
            $error("cosp_ctrl: N_SRC must be at least 1");
        end
        if (N_PCI < 1) begin : g_chk_pci
            $error("cosp_ctrl: N_PCI must be at least 1");
        end
        if (N_FREE_RUNNING_PCI_CLOCK < 1) begin : g_chk_free_running_pci_clock
            $error("cosp_ctrl: N_FREE_RUNNING_PCI_CLOCK must be at least 1");
        end
        if (PWRUP_CYC < 2) begin : g_chk_tmr
            $error("cosp_ctrl: PWRUP_CYC must be at least 2");
        end
        if (PWRUP_CYC > cosp_pkg::PWRUP_MAX_CYC) begin : g_chk_tmr_max
            $error("cosp_ctrl: PWRUP_CYC exceeds the power-up latency limit");
        end
    endgenerate

    typedef struct packed {
        cosp_pkg::cosp_state_t state;
        logic pd_s1;
        logic pd_s2;
        logic cs_s1;
        logic cs_s2;
        logic ps_s1;
        logic ps_s2;
        logic cpu_prev;
        logic src_prev;
        logic pci_prev;
        logic [1:0] pd_cnt;
        logic [1:0] cs_cnt;
        logic [1:0] ss_cnt;
        logic cpu_stop;
        logic src_stop;
        logic pci_stop;
        logic [N_CPU-1:0] cpu_hold;
        logic cpu_off;
        logic [N_SRC-1:0] src_hold;
        logic src_off;
        logic pci_off;
        logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_off;
        logic [N_CPU-1:0] cpu_t;
        logic [N_CPU-1:0] cpu_c;
        logic [N_SRC-1:0] src_t;
        logic [N_SRC-1:0] src_c;
        logic [N_PCI-1:0] pci_o;
        logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_o;
        logic synth_en;
        logic diff_oe;
        logic valid;
        logic late;
        logic [TW-1:0] tmr;
    } cosp_regs_t;

    // Reset: outputs forced low, stop synchronisers at their idle high level
    localparam cosp_regs_t RST_VAL = '{
        state: cosp_pkg::ST_WAIT_PG,
        pd_s1: 1'b0,
        pd_s2: 1'b0,
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        ps_s1: 1'b1,
        ps_s2: 1'b1,
        cpu_prev: 1'b0,
        src_prev: 1'b0,
        pci_prev: 1'b0,
        pd_cnt: 2'h0,
        cs_cnt: 2'h0,
        ss_cnt: 2'h0,
        cpu_stop: 1'b0,
        src_stop: 1'b0,
        pci_stop: 1'b0,
        cpu_hold: '0,
        cpu_off: 1'b1,
        src_hold: '0,
        src_off: 1'b1,
        pci_off: 1'b1,
        free_running_pci_clock_off: '1,
        cpu_t: '0,
        cpu_c: '0,
        src_t: '0,
        src_c: '0,
        pci_o: '0,
        free_running_pci_clock_o: '0,
        synth_en: 1'b0,
        diff_oe: 1'b0,
        valid: 1'b0,
        late: 1'b0,
        tmr: '0
    };

    cosp_regs_t r_r;
    cosp_regs_t r_nxt;

    // Edge detectors on the raw synthesizer clocks
    function automatic logic fell_edge(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : fell_edge

    function automatic logic rose_edge(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction : rose_edge

    // One differential leg: a parked leg holds, a forced-off leg stays low
    function automatic logic pair_true(input logic off, input logic hold, input logic clk);
        return ~off & (hold | clk);
    endfunction : pair_true

    function automatic logic pair_comp(input logic off, input logic hold, input logic clk);
        return ~off & ~(hold | clk);
    endfunction : pair_comp

    // Counts consecutive complement rising edges while a request stays low
    function automatic logic [1:0] cnt_step(input logic [1:0] cnt, input logic edge_seen,
                                            input logic active);
        logic [1:0] res;
        res = cnt;
        if (!active) begin
            res = 2'h0;
        end else if (edge_seen && cnt < cosp_pkg::SAMPLE_EDGES) begin
            res = cnt + 2'h1;
        end
        return res;
    endfunction : cnt_step

    logic cpu_fall;
    logic src_fall;
    logic pci_rise;
    logic run;
    logic all_low;

    always_comb begin
        r_nxt = r_r;
        // Two-stage synchronisers for the pins
        r_nxt.pd_s1 = i_power_good_strobe;
        r_nxt.pd_s2 = r_r.pd_s1;
        r_nxt.cs_s1 = i_cpu_clock_stop_n;
        r_nxt.cs_s2 = r_r.cs_s1;
        r_nxt.ps_s1 = i_pci_refclk_stop_n;
        r_nxt.ps_s2 = r_r.ps_s1;
        r_nxt.cpu_prev = i_cpu_clk;
        r_nxt.src_prev = i_src_clk;
        r_nxt.pci_prev = i_pci_clk;
        r_nxt.valid = 1'b0;
        // Complement rises when the true phase falls
        cpu_fall = fell_edge(r_r.cpu_prev, i_cpu_clk);
        src_fall = fell_edge(r_r.src_prev, i_src_clk);
        pci_rise = rose_edge(r_r.pci_prev, i_pci_clk);
        run = (r_r.state == cosp_pkg::ST_RUN);

        r_nxt.pd_cnt = cnt_step(r_r.pd_cnt, cpu_fall, ~r_r.pd_s2 & run);
        r_nxt.cs_cnt = cnt_step(r_r.cs_cnt, cpu_fall, ~r_r.cs_s2);
        r_nxt.ss_cnt = cnt_step(r_r.ss_cnt, src_fall, ~r_r.ps_s2);
        r_nxt.cpu_stop = (r_r.cs_cnt == cosp_pkg::SAMPLE_EDGES);
        r_nxt.src_stop = (r_r.ss_cnt == cosp_pkg::SAMPLE_EDGES);
        if (r_r.ps_s2) begin
            r_nxt.pci_stop = 1'b0;
        end else if (pci_rise) begin
            r_nxt.pci_stop = 1'b1;
        end

        // Park and release only while the true phase is high
        if (i_cpu_clk) begin
            r_nxt.cpu_hold = {N_CPU{r_r.cpu_stop}} & i_cpu_stoppable;
        end
        if (i_src_clk) begin
            r_nxt.src_hold = {N_SRC{r_r.src_stop}} & i_src_stoppable;
        end
        // Force low or release only while the phase is low, except in ST_PD_OFF, which forces every output low at once
        if (!i_cpu_clk) begin
            r_nxt.cpu_off = ~run;
        end
        if (!i_src_clk) begin
            r_nxt.src_off = ~run;
        end
        if (!i_pci_clk) begin
            r_nxt.pci_off = ~run | r_r.pci_stop;
            r_nxt.free_running_pci_clock_off = {N_FREE_RUNNING_PCI_CLOCK{~run}} | ({N_FREE_RUNNING_PCI_CLOCK{r_r.pci_stop}} & i_free_running_pci_clock_stoppable);
        end
        if (r_r.state == cosp_pkg::ST_PD_OFF) begin
            r_nxt.cpu_off = 1'b1;
            r_nxt.src_off = 1'b1;
            r_nxt.pci_off = 1'b1;
            r_nxt.free_running_pci_clock_off = '1;
        end

        // Output stage
        // Pair legs
        for (int k = 0; k < N_CPU; k++) begin
            r_nxt.cpu_t[k] = pair_true(r_r.cpu_off, r_r.cpu_hold[k], i_cpu_clk);
            r_nxt.cpu_c[k] = pair_comp(r_r.cpu_off, r_r.cpu_hold[k], i_cpu_clk);
        end
        for (int k = 0; k < N_SRC; k++) begin
            r_nxt.src_t[k] = pair_true(r_r.src_off, r_r.src_hold[k], i_src_clk);
            r_nxt.src_c[k] = pair_comp(r_r.src_off, r_r.src_hold[k], i_src_clk);
        end
        r_nxt.pci_o = {N_PCI{~r_r.pci_off & i_pci_clk}};
        r_nxt.free_running_pci_clock_o = ~r_r.free_running_pci_clock_off & {N_FREE_RUNNING_PCI_CLOCK{i_pci_clk}};

        all_low = r_r.cpu_off & r_r.src_off & r_r.pci_off & (&r_r.free_running_pci_clock_off);

        case (r_r.state)
            cosp_pkg::ST_WAIT_PG: begin
                r_nxt.synth_en = 1'b0;
                r_nxt.diff_oe = 1'b0;
                if (r_r.pd_s2) begin
                    r_nxt.valid = 1'b1;
                    r_nxt.tmr = '0;
                    r_nxt.late = 1'b0;
                    r_nxt.state = cosp_pkg::ST_WAKE;
                end
            end
            cosp_pkg::ST_WAKE: begin
                r_nxt.synth_en = 1'b1;
                r_nxt.diff_oe = 1'b1;
                if (r_r.tmr < TW'(PWRUP_CYC)) begin
                    r_nxt.tmr = r_r.tmr + TW'(1);
                end
                if (r_r.tmr == TW'(PWRUP_CYC - 1)) begin
                    r_nxt.late = 1'b1;
                end
                if (!r_r.pd_s2) begin
                    r_nxt.state = cosp_pkg::ST_PD_STOP;
                end else if (i_pll_locked) begin
                    r_nxt.state = cosp_pkg::ST_RUN;
                end
            end
            cosp_pkg::ST_RUN: begin
                r_nxt.synth_en = 1'b1;
                r_nxt.diff_oe = 1'b1;
                if (r_r.pd_cnt == cosp_pkg::SAMPLE_EDGES) begin
                    r_nxt.state = cosp_pkg::ST_PD_STOP;
                end
            end
            cosp_pkg::ST_PD_STOP: begin
                r_nxt.synth_en = 1'b1;
                r_nxt.diff_oe = 1'b1;
                if (all_low || !i_pll_locked) begin
                    r_nxt.state = cosp_pkg::ST_PD_OFF;
                end
            end
            cosp_pkg::ST_PD_OFF: begin
                r_nxt.synth_en = 1'b0;
                r_nxt.diff_oe = 1'b0;
                if (r_r.pd_s2) begin
                    r_nxt.tmr = '0;
                    r_nxt.late = 1'b0;
                    r_nxt.state = cosp_pkg::ST_WAKE;
                end
            end
            default: begin
                r_nxt.state = cosp_pkg::ST_WAIT_PG;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            r_r <= RST_VAL;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign o_cpu_clock_true = r_r.cpu_t;
    assign o_cpu_clock_complement = r_r.cpu_c;
    assign o_pcie_reference_clock_true = r_r.src_t;
    assign o_pcie_reference_clock_complement = r_r.src_c;
    assign o_pci_clock = r_r.pci_o;
    assign o_free_running_pci_clock = r_r.free_running_pci_clock_o;
    assign o_diff_oe = r_r.diff_oe;
    assign o_synth_enable = r_r.synth_en;
    assign o_inputs_valid = r_r.valid;
    assign o_powerup_late = r_r.late;
    assign o_clocks_running = (r_r.state == cosp_pkg::ST_RUN);

endmodule : cosp_ctrl

`default_nettype wire

// ==== bench/cosp_monitor.sv ====
// Checker for clock stop and power-down sequencing
`timescale 1ns/10ps
`default_nettype none
module cosp_monitor #(
    parameter int N_CPU = 2,
    parameter int N_PCI = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_power_good_strobe,
    input wire logic i_cpu_clock_stop_n,
    input wire logic i_pci_refclk_stop_n,
    input wire logic i_pll_locked,
    input wire logic [N_CPU-1:0] i_cpu_stoppable,
    input wire logic [N_CPU-1:0] o_cpu_clock_true,
    input wire logic [N_CPU-1:0] o_cpu_clock_complement,
    input wire logic [N_PCI-1:0] o_pci_clock,
    input wire logic o_diff_oe,
    input wire logic o_synth_enable,
    input wire logic o_inputs_valid,
    input wire logic o_clocks_running
);
    logic [6:0] cstop_cnt_r;
    logic [6:0] pstop_cnt_r;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    // Cycles a stop pin has been low while running (bench clocks have 8-cycle periods)
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cstop_cnt_r <= 7'h00;
            pstop_cnt_r <= 7'h00;
        end else begin
            cstop_cnt_r <= (i_cpu_clock_stop_n || !o_clocks_running) ? 7'h00 :
                cstop_cnt_r + {6'h00, cstop_cnt_r != 7'h7F};
            pstop_cnt_r <= (i_pci_refclk_stop_n || !o_clocks_running) ? 7'h00 :
                pstop_cnt_r + {6'h00, pstop_cnt_r != 7'h7F};
        end
    end
    AST_VALID_PULSE: assert property (o_inputs_valid |=>
        !o_inputs_valid && o_synth_enable && o_diff_oe) else $error("valid pulse");
    AST_OE_SYNTH: assert property (o_diff_oe == o_synth_enable)
        else $error("oe and synth differ");
    AST_PD_LOW: assert property ($fell(o_synth_enable) && i_pll_locked |->
        o_cpu_clock_true == '0 && o_cpu_clock_complement == '0 && o_pci_clock == '0)
        else $error("synth off before clocks low");
    AST_PD_SYNC: assert property ($fell(i_power_good_strobe) && o_clocks_running
        |=> o_synth_enable [*3]) else $error("power-down taken unsynchronised");
    AST_RUN_ON: assert property ($rose(o_clocks_running) |->
        $past(i_pll_locked) && o_diff_oe) else $error("run without lock");
    AST_NO_BOTH_HIGH: assert property ((o_cpu_clock_true & o_cpu_clock_complement)
        == '0) else $error("pair both high");
    AST_CPU_PARK: assert property (cstop_cnt_r == 7'h46 |->
        (o_cpu_clock_true & i_cpu_stoppable) == i_cpu_stoppable &&
        (o_cpu_clock_complement & i_cpu_stoppable) == '0) else $error("cpu not parked");
    AST_CPU_RESTART: assert property ($rose(i_cpu_clock_stop_n) && o_clocks_running
        |-> ##[1:24] !(&o_cpu_clock_true)) else $error("cpu restart late");
    AST_PCI_STOP: assert property (pstop_cnt_r == 7'h28 |-> o_pci_clock == '0)
        else $error("pci not stopped");
    AST_PCI_RESUME: assert property ($rose(i_pci_refclk_stop_n) && o_clocks_running
        |-> ##[1:24] (|o_pci_clock)) else $error("pci resume late");
    COV_CPU_PARK: cover property (cstop_cnt_r == 7'h46);
    COV_PCI_STOP: cover property (pstop_cnt_r == 7'h28);
    COV_PD_OFF: cover property ($fell(o_synth_enable));
endmodule : cosp_monitor
bind cosp_ctrl cosp_monitor #(.N_CPU(N_CPU), .N_PCI(N_PCI)) cosp_monitor_i (.i_clk_sys,
    .i_resetn, .i_power_good_strobe, .i_cpu_clock_stop_n, .i_pci_refclk_stop_n,
    .i_pll_locked, .i_cpu_stoppable, .o_cpu_clock_true, .o_cpu_clock_complement,
    .o_pci_clock, .o_diff_oe, .o_synth_enable, .o_inputs_valid, .o_clocks_running);
`default_nettype wire

// ==== bench/cosp_platform.sv ====
// Platform control model driving the power and stop pins
`timescale 1ns/10ps
`default_nettype none
module cosp_platform (
    input wire logic i_clk,
    input wire logic [2:0] i_req,
    output logic o_power_good_strobe,
    output logic o_cpu_clock_stop_n,
    output logic o_pci_refclk_stop_n
);
    initial {o_power_good_strobe, o_cpu_clock_stop_n, o_pci_refclk_stop_n} = 3'h3;
    // Pins move just after an edge; each pin follows its own request bit
    always @(posedge i_clk) begin
        {o_power_good_strobe, o_cpu_clock_stop_n, o_pci_refclk_stop_n} <= #1 i_req;
    end
endmodule : cosp_platform
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for clock stop and power-down sequencing
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_clk_sys, i_resetn, i_pll_locked, pg, cs_n, ps_n, oe, se, iv, late, run;
    logic [2:0] req, div = 3'h0;
    logic [1:0] cstop, ct, cc;
    logic [2:0] sstop, st, sc;
    logic [0:0] fstop, pc, fc;
    logic [11:0] or_v, and_v;
    logic [31:0] rnd;
    integer seed = 72;
    int err_count = 0;
    int cmp_count = 0;
    cosp_platform cosp_platform_i (.i_clk(i_clk_sys), .i_req(req),
        .o_power_good_strobe(pg), .o_cpu_clock_stop_n(cs_n), .o_pci_refclk_stop_n(ps_n));
    cosp_ctrl #(.PWRUP_CYC(50)) cosp_ctrl_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_power_good_strobe(pg), .i_cpu_clock_stop_n(cs_n), .i_pci_refclk_stop_n(ps_n),
        .i_cpu_clk(div[2]), .i_src_clk(div[2]), .i_pci_clk(div[2]),
        .i_pll_locked(i_pll_locked), .i_cpu_stoppable(cstop), .i_src_stoppable(sstop),
        .i_free_running_pci_clock_stoppable(fstop), .o_cpu_clock_true(ct), .o_cpu_clock_complement(cc),
        .o_pcie_reference_clock_true(st), .o_pcie_reference_clock_complement(sc),
        .o_pci_clock(pc), .o_free_running_pci_clock(fc), .o_diff_oe(oe),
        .o_synth_enable(se), .o_inputs_valid(iv), .o_powerup_late(late),
        .o_clocks_running(run));
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) div <= #1 div + 3'h1;
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : step
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk
    // Outputs that should stay high and stay low for a stop mode
    function automatic logic [23:0] park(input int m);
        logic [11:0] hi, lo;
        hi = 12'h000;
        lo = 12'h000;
        if (m == 1) begin
            hi[11:10] = cstop;
            lo[9:8] = cstop;
        end
        if (m == 2) begin
            hi[7:5] = sstop;
            lo[4:2] = sstop;
            lo[1] = 1'b1;
            lo[0] = fstop[0];
        end
        return {hi, lo};
    endfunction : park
    task automatic watch(input int m);
        logic [23:0] x;
        x = park(m);
        or_v = 12'h000;
        and_v = 12'hFFF;
        repeat (10) begin
            step(1);
            or_v = or_v | {ct, cc, st, sc, pc, fc};
            and_v = and_v & {ct, cc, st, sc, pc, fc};
        end
        chk((and_v & x[23:12]) === x[23:12] && (or_v & x[11:0]) === 12'h000 &&
            (or_v & ~and_v) === ~(x[23:12] | x[11:0]), "output levels");
    endtask : watch
    task automatic run_stop(input int m);
        req[2 - m] = 1'b0;
        step(80);
        watch(m);
        req[2 - m] = 1'b1;
        step(30);
        watch(0);
    endtask : run_stop
    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #(8 * 6000);
        err_count++;
        report_and_stop();
    end
    initial begin
        i_resetn = 1'b0;
        i_pll_locked = 1'b0;
        req = 3'h3;
        {cstop, sstop, fstop} = 6'h3F;
        step(4);
        i_resetn = 1'b1;
        step(2);
        req[2] = 1'b1;
        for (int k = 0; k < 20 && iv !== 1'b1; k++) step(1);
        step(1);
        chk(iv === 1'b0 && se === 1'b1 && oe === 1'b1, "wake");
        step(80);
        i_pll_locked = 1'b1;
        for (int k = 0; k < 20 && run !== 1'b1; k++) step(1);
        chk(run === 1'b1 && late === 1'b1, "late lock");
        for (int i = 0; i < 4; i++) begin
            rnd = (i == 0) ? 32'h3F : $random(seed);
            {cstop, sstop, fstop} = rnd[5:0];
            run_stop(1);
            run_stop(2);
        end
        req[2] = 1'b0;
        for (int k = 0; k < 60 && se !== 1'b0; k++) step(1);
        chk({se, oe, ct, cc, pc} === 7'h00, "power down");
        i_pll_locked = 1'b0;
        step(5);
        req[2] = 1'b1;
        for (int k = 0; k < 20 && oe !== 1'b1; k++) step(1);
        chk(oe === 1'b1, "pairs driven");
        step(10);
        i_pll_locked = 1'b1;
        for (int k = 0; k < 20 && run !== 1'b1; k++) step(1);
        chk(run === 1'b1 && late === 1'b0, "rewake");
        step(8);
        watch(0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
